// file: dsd_far_model.sv
// far side of the decoder: data-space targets and the eeprom byte array
// assumes one core clock; read data stands during each read pulse
`timescale 1ns/1ps
module dsd_far_model (
  // clock
  input wire logic CORE_CLK,
  // data space
  input wire logic [15:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic [7:0] WMASK,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] EXT_RDATA,
  // eeprom array
  input wire logic [8:0] EE_ADDR,
  input wire logic [7:0] EE_WDATA,
  input wire logic EE_WR,
  input wire logic EE_RD,
  output logic [7:0] EE_RDATA
);
  logic [7:0] mem [1024];
  logic [7:0] ee [512];
  initial begin
    for (int i = 0; i < 1024; i++) mem[i] = 8'h00;
  end
  always @(posedge CORE_CLK) begin
    // masked write, so bit ops that disturb other bits show up
    if (WR === 1'b1) mem[ADDR[9:0]] <= (mem[ADDR[9:0]] & ~WMASK) | (WDATA & WMASK);
    if (EE_WR === 1'b1) ee[EE_ADDR] <= EE_WDATA;
  end
  // decoder takes data at the edge ending the pulse; otherwise the inverse, never a stale copy
  assign EXT_RDATA = (RD === 1'b1) ? mem[ADDR[9:0]] : ~mem[ADDR[9:0]];
  assign EE_RDATA = (EE_RD === 1'b1) ? ee[EE_ADDR] : ~ee[EE_ADDR];
endmodule // dsd_far_model

// file: dsd_pkg.sv
// data-space decoder constants, types and carriers
// assumes one core clock at 100 MHz
package dsd_pkg;
  // region boundaries: 32 regs, 64 io, 160 ext io, then sram
  localparam logic [15:0] REG_END = 16'h0020;
  localparam logic [15:0] IO_END = 16'h0060;
  localparam logic [15:0] XIO_END = 16'h0100;
  localparam logic [15:0] IO_OFS = 16'h0020;
  // io addresses of the block's own registers
  localparam logic [5:0] IO_FLAG = 6'h1d;
  localparam logic [5:0] IO_GPR0 = 6'h1e;
  localparam logic [5:0] IO_EECTL = 6'h1f;
  localparam logic [5:0] IO_EEDAT = 6'h20;
  localparam logic [5:0] IO_EEADL = 6'h21;
  localparam logic [5:0] IO_EEADH = 6'h22;
  localparam logic [5:0] IO_GPR1 = 6'h2a;
  localparam logic [5:0] IO_GPR2 = 6'h2b;
  // control register fields
  localparam int EC_RE = 0;
  localparam int EC_WS = 1;
  localparam int EC_MWE = 2;
  localparam int EC_RIE = 3;
  localparam int EC_PM0 = 4;
  localparam int FL_WDONE = 0;
  localparam logic [7:0] EC_PM_MASK = 8'h30;
  localparam logic [1:0] EE_PM_RST = 2'h0;
  // timing
  localparam logic [2:0] MWE_CYC = 3'h4;
  localparam logic [2:0] EERD_STALL = 3'h4;
  localparam logic [2:0] EEWR_STALL = 3'h2;
  localparam int CLK_PERIOD_PS = 10000;
  localparam longint EE_WR_TIME_PS = 64'd3300000000;
  localparam int EE_WR_CYC_DEF = int'((EE_WR_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int PM_WORDS_DEF = 4096;
  localparam int EE_BYTES_DEF = 512;

  typedef enum logic [2:0] {OP_LOAD, OP_STORE, OP_IN, OP_OUT, OP_SBI, OP_CLRB, OP_SKBS, OP_SKBC} dsd_op_e;
  typedef enum logic [2:0] {AM_DIR, AM_DISP, AM_IND, AM_PRED, AM_POST} dsd_am_e;
  typedef enum logic [1:0] {PT_X, PT_Y, PT_Z} dsd_ptr_e;
  typedef struct packed {
    logic sram;
    logic xio;
    logic io;
    logic rf;
  } dsd_tgt_s;
  typedef struct packed {
    dsd_op_e op;
    dsd_am_e am;
    dsd_ptr_e ptr;
    logic [5:0] disp;
    logic [15:0] adr;
    logic [5:0] ioa;
    logic [2:0] bitn;
    logic [7:0] wdat;
  } dsd_req_s;
endpackage

// file: dsd_top.sv
// data-space decoder: routes core accesses, own io regs, eeprom control
// assumes core gives pointer value with request, ext data valid while RD is high
//
// Function
// [R01] regs, io, ext io, sram by address
// [R02] ext io only by load/store
// [R03] port io address plus 0x20
// [R04] bit ops only io 0x00-0x1f
// [R05] bit ops write addressed bit only
// [R06] status flags clear on written one
// [R07] sram access takes two cycles
// [R08] direct addressing reaches whole space
// [R09] displacement up to 63 on pointer
// [R10] pre-decrement and post-increment pointer update
// [R11] stall four after read, two after write
// [R12] program memory 16-bit words, pc width
// [R13] eeprom separate byte-wide space
// [R14] eeprom registers live in io space
// [R15] eeprom write survives system reset
// [R16] three general purpose io registers
// [R17] software writes reserved bits zero
// [R18] write strobe needs master enable recently
// [R19] exactly one target per access
`timescale 1ns/1ps
module dsd_top import dsd_pkg::*; #(
  parameter int PM_WORDS = PM_WORDS_DEF,
  parameter int EE_BYTES = EE_BYTES_DEF,
  parameter int EE_WR_CYC = EE_WR_CYC_DEF
) (
  // clock and resets
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic PWR_RST,
  // core request
  input wire logic REQ_VALID,
  input wire dsd_req_s REQ,
  input wire logic [15:0] PTR_IN,
  output logic READY,
  output logic DONE,
  output logic SKIP,
  output logic [7:0] RDATA,
  // pointer write-back
  output logic PTR_WE,
  output dsd_ptr_e PTR_SEL,
  output logic [15:0] PTR_OUT,
  // data space side
  output dsd_tgt_s TGT,
  output logic [15:0] ADDR,
  output logic [7:0] WDATA,
  output logic [7:0] WMASK,
  output logic WR,
  output logic RD,
  input wire logic [7:0] EXT_RDATA,
  // eeprom array
  output logic [$clog2(EE_BYTES)-1:0] EE_ADDR,
  output logic [7:0] EE_WDATA,
  output logic [1:0] EE_MODE,
  output logic EE_WR,
  output logic EE_RD,
  input wire logic [7:0] EE_RDATA,
  output logic EE_BUSY,
  output logic EE_READY_INT
);
  localparam int PC_W = $clog2(PM_WORDS); // [R12]
  localparam int EEA_W = $clog2(EE_BYTES); // [R13]

  typedef enum {ST_IDLE, ST_WAIT, ST_STALL} dsd_st_e;
  dsd_st_e st_ff;

  function automatic dsd_tgt_s tgt_of(input logic [15:0] a);
    dsd_tgt_s t;
    t = '0;
    if (a < REG_END) t.rf = 1'b1; // [R01] [R19]
    else if (a < IO_END) t.io = 1'b1;
    else if (a < XIO_END) t.xio = 1'b1;
    else t.sram = 1'b1;
    return t;
  endfunction

  function automatic logic [7:0] wmerge(input logic [7:0] o, input logic [7:0] m, input logic [7:0] v);
    return (o & ~m) | (v & m); // [R05]
  endfunction

  logic [15:0] adr16;
  logic [7:0] gpr0_ff, gpr1_ff, gpr2_ff, eedat_ff, eadl_ff, eadh_ff;
  logic [1:0] pm_ff;
  logic rie_ff, busy_ff, wdone_ff, eerd_ff;
  logic [2:0] mwe_ff, stl_ff;
  logic [19:0] tmr_ff;
  logic [15:0] c_ea, c_pnv;
  logic c_pwe, c_wr, c_bit, c_bt, c_intl, c_need2, take;
  logic [5:0] c_ioa;
  logic [7:0] c_mask, c_val, c_one, c_ird;
  dsd_tgt_s c_tgt;
  logic c_ctl, c_srd, c_swr;
  logic [7:0] adh_mask;
  logic [7:0] c_pmw;
  logic bt_ff, skset_ff;
  logic [2:0] bn_ff;

  assign adh_mask = 8'((EE_BYTES - 1) >> 8);
  assign adr16 = {eadh_ff & adh_mask, eadl_ff};
  assign take = REQ_VALID && READY;

  always_comb begin
    c_ea = REQ.adr;
    c_pwe = 1'b0;
    c_pnv = PTR_IN;
    case (REQ.op)
      OP_IN, OP_OUT: c_ea = IO_OFS + {10'h000, REQ.ioa}; // [R03] [R02]
      OP_SBI, OP_CLRB, OP_SKBS, OP_SKBC: c_ea = IO_OFS + {11'h000, REQ.ioa[4:0]}; // [R04]
      default: begin
        case (REQ.am)
          AM_DIR: c_ea = REQ.adr; // [R08]
          AM_DISP: c_ea = PTR_IN + {10'h000, REQ.disp}; // [R09]
          AM_IND: c_ea = PTR_IN;
          AM_PRED: begin
            c_ea = PTR_IN - 16'h0001; // [R10]
            c_pwe = 1'b1;
            c_pnv = PTR_IN - 16'h0001;
          end
          AM_POST: begin
            c_ea = PTR_IN;
            c_pwe = 1'b1;
            c_pnv = PTR_IN + 16'h0001; // [R10]
          end
          default: c_ea = REQ.adr;
        endcase
      end
    endcase
  end

  always_comb begin
    c_tgt = tgt_of(c_ea);
    c_ioa = 6'(c_ea[7:0] - IO_OFS[7:0]);
    c_intl = c_tgt.io && (c_ioa inside {IO_FLAG, IO_GPR0, IO_EECTL, IO_EEDAT,
      IO_EEADL, IO_EEADH, IO_GPR1, IO_GPR2}); // [R14] [R16]
    c_wr = REQ.op inside {OP_STORE, OP_OUT, OP_SBI, OP_CLRB};
    c_bit = REQ.op inside {OP_SBI, OP_CLRB, OP_SKBS, OP_SKBC};
    c_bt = REQ.op inside {OP_SKBS, OP_SKBC};
    c_mask = c_bit ? (8'h01 << REQ.bitn) : 8'hff; // [R05]
    c_val = (REQ.op == OP_SBI) ? c_mask : ((REQ.op == OP_CLRB) ? 8'h00 : REQ.wdat);
    c_one = c_mask & c_val;
    c_pmw = wmerge({2'h0, pm_ff, 4'h0}, c_mask & EC_PM_MASK, c_val);
    // sram always two cycles; ext reads wait for data
    c_need2 = c_tgt.sram || (!c_wr && !c_intl && !c_tgt.rf); // [R07]
    c_ctl = take && c_wr && c_intl && c_ioa == IO_EECTL;
    c_srd = c_ctl && c_one[EC_RE] && !busy_ff;
    c_swr = c_ctl && c_one[EC_WS] && mwe_ff != 3'h0 && !busy_ff; // [R18]
    case (c_ioa)
      IO_FLAG: c_ird = {7'h00, wdone_ff};
      IO_GPR0: c_ird = gpr0_ff;
      IO_GPR1: c_ird = gpr1_ff;
      IO_GPR2: c_ird = gpr2_ff;
      IO_EECTL: c_ird = {2'h0, pm_ff, rie_ff, mwe_ff != 3'h0, busy_ff, 1'b0};
      IO_EEDAT: c_ird = eedat_ff;
      IO_EEADL: c_ird = eadl_ff;
      IO_EEADH: c_ird = eadh_ff & adh_mask;
      default: c_ird = 8'h00;
    endcase
  end

  // general purpose storage
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      gpr0_ff <= 8'h00;
      gpr1_ff <= 8'h00;
      gpr2_ff <= 8'h00;
    end else if (take && c_wr && c_intl) begin
      if (c_ioa == IO_GPR0) gpr0_ff <= wmerge(gpr0_ff, c_mask, c_val); // [R16]
      if (c_ioa == IO_GPR1) gpr1_ff <= wmerge(gpr1_ff, c_mask, c_val);
      if (c_ioa == IO_GPR2) gpr2_ff <= wmerge(gpr2_ff, c_mask, c_val);
    end
  end

  // eeprom address and data; address writes ignored while busy, system reset still clears it
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      eedat_ff <= 8'h00;
      eadl_ff <= 8'h00;
      eadh_ff <= 8'h00;
      eerd_ff <= 1'b0;
    end else begin
      eerd_ff <= c_srd;
      if (eerd_ff) eedat_ff <= EE_RDATA; // [R13]
      else if (take && c_wr && c_intl && c_ioa == IO_EEDAT) eedat_ff <= wmerge(eedat_ff, c_mask, c_val);
      if (take && c_wr && c_intl && !busy_ff) begin
        if (c_ioa == IO_EEADL) eadl_ff <= wmerge(eadl_ff, c_mask, c_val);
        if (c_ioa == IO_EEADH) eadh_ff <= wmerge(eadh_ff, c_mask, c_val) & adh_mask;
      end
    end
  end

  // control bits; mode kept through reset while busy
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      rie_ff <= 1'b0;
      mwe_ff <= 3'h0;
      if (!busy_ff) pm_ff <= EE_PM_RST;
    end else begin
      if (c_ctl && c_mask[EC_RIE]) rie_ff <= c_val[EC_RIE];
      if (c_ctl && !busy_ff) pm_ff <= c_pmw[EC_PM0+:2];
      if (c_ctl && c_one[EC_MWE]) mwe_ff <= MWE_CYC; // [R18]
      else if (mwe_ff != 3'h0) mwe_ff <= mwe_ff - 3'h1;
    end
  end

  // write timer runs on through system reset, only power reset stops it
  always_ff @(posedge CORE_CLK) begin
    if (PWR_RST) begin
      busy_ff <= 1'b0;
      tmr_ff <= 20'h00000;
    end else if (c_swr && !RST) begin
      busy_ff <= 1'b1;
      tmr_ff <= 20'(EE_WR_CYC);
    end else if (busy_ff) begin
      tmr_ff <= tmr_ff - 20'h00001; // [R15]
      if (tmr_ff == 20'h00001) busy_ff <= 1'b0;
    end
  end

  // write-done flag: one clears, zero keeps, set wins
  always_ff @(posedge CORE_CLK) begin
    if (RST) wdone_ff <= 1'b0;
    else if (busy_ff && tmr_ff == 20'h00001) wdone_ff <= 1'b1;
    else if (take && c_wr && c_intl && c_ioa == IO_FLAG && c_one[FL_WDONE]) wdone_ff <= 1'b0; // [R06]
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      EE_WR <= 1'b0;
      EE_RD <= 1'b0;
      EE_READY_INT <= 1'b0;
    end else begin
      EE_WR <= c_swr;
      EE_RD <= c_srd;
      EE_READY_INT <= rie_ff && !busy_ff;
    end
  end
  assign EE_ADDR = adr16[EEA_W-1:0];
  assign EE_WDATA = eedat_ff;
  assign EE_MODE = pm_ff;
  assign EE_BUSY = busy_ff;

  // access sequencing and stalls
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      st_ff <= ST_IDLE;
      READY <= 1'b1;
      DONE <= 1'b0;
      stl_ff <= 3'h0;
    end else begin
      DONE <= 1'b0;
      case (st_ff)
        ST_IDLE: if (take) begin
          if (c_need2) begin
            st_ff <= ST_WAIT;
            READY <= 1'b0;
          end else if (c_srd || c_swr) begin
            st_ff <= ST_STALL;
            READY <= 1'b0;
            stl_ff <= c_srd ? EERD_STALL : EEWR_STALL; // [R11]
          end
          DONE <= !c_need2;
        end
        ST_WAIT: begin
          DONE <= 1'b1; // [R07]
          READY <= 1'b1;
          st_ff <= ST_IDLE;
        end
        ST_STALL: begin
          stl_ff <= stl_ff - 3'h1;
          if (stl_ff == 3'h1) begin
            READY <= 1'b1;
            st_ff <= ST_IDLE;
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // data-space strobes and results
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      TGT <= '0;
      ADDR <= 16'h0000;
      WDATA <= 8'h00;
      WMASK <= 8'h00;
      WR <= 1'b0;
      RD <= 1'b0;
      RDATA <= 8'h00;
      SKIP <= 1'b0;
      PTR_WE <= 1'b0;
      PTR_SEL <= PT_X;
      PTR_OUT <= 16'h0000;
    end else begin
      WR <= take && c_wr && !c_intl;
      RD <= take && !c_wr && !c_intl;
      PTR_WE <= take && c_pwe; // [R10]
      if (take) begin
        TGT <= c_tgt; // [R19]
        ADDR <= c_ea;
        WDATA <= c_val;
        WMASK <= c_mask; // [R05]
        PTR_SEL <= REQ.ptr;
        PTR_OUT <= c_pnv;
        RDATA <= c_ird;
        SKIP <= c_bt && (c_ird[REQ.bitn] == (REQ.op == OP_SKBS));
      end else if (st_ff == ST_WAIT && RD) begin
        RDATA <= EXT_RDATA;
        SKIP <= bt_ff && (EXT_RDATA[bn_ff] == skset_ff);
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      bt_ff <= 1'b0;
      skset_ff <= 1'b0;
      bn_ff <= 3'h0;
    end else if (take) begin
      bt_ff <= c_bt;
      skset_ff <= REQ.op == OP_SKBS;
      bn_ff <= REQ.bitn;
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST || PWR_RST);

  sequence s_eerd_stall;
    !READY [*4] ##1 READY;
  endsequence
  sequence s_sram_two;
    !DONE && (RD || WR) ##1 DONE;
  endsequence

  property p_r01_map;
    DONE && !WR && !RD |-> (TGT.rf == (ADDR < REG_END)) && (TGT.sram == (ADDR >= XIO_END));
  endproperty
  a_r01_map: assert property (p_r01_map) else $error("target does not match address"); // [R01]
  property p_r19_one;
    $rose(DONE) |-> $onehot(TGT);
  endproperty
  a_r19_one: assert property (p_r19_one) else $error("not exactly one target"); // [R19]
  property p_r02_port;
    take && REQ.op inside {OP_IN, OP_OUT} |=> ADDR < IO_END && TGT.io;
  endproperty
  a_r02_port: assert property (p_r02_port) else $error("port op left io space"); // [R02]
  property p_r03_ofs;
    take && REQ.op == OP_OUT |=> ADDR == IO_OFS + {10'h000, $past(REQ.ioa)};
  endproperty
  a_r03_ofs: assert property (p_r03_ofs) else $error("io offset wrong"); // [R03]
  property p_r05_bit;
    take && c_bit |=> $onehot(WMASK) && ADDR < IO_OFS + REG_END;
  endproperty
  a_r05_bit: assert property (p_r05_bit) else $error("bit op not single bit"); // [R05]
  property p_r07_sram;
    take && c_tgt.sram |=> s_sram_two;
  endproperty
  a_r07_sram: assert property (p_r07_sram) else $error("sram access not two cycles"); // [R07]
  property p_r09_disp;
    take && REQ.am == AM_DISP && !c_bit && !(REQ.op inside {OP_IN, OP_OUT})
      |=> ADDR == $past(PTR_IN) + {10'h000, $past(REQ.disp)};
  endproperty
  a_r09_disp: assert property (p_r09_disp) else $error("displacement wrong"); // [R09]
  property p_r10_post;
    take && c_pwe && REQ.am == AM_POST |=> PTR_WE && PTR_OUT == $past(PTR_IN) + 16'h0001;
  endproperty
  a_r10_post: assert property (p_r10_post) else $error("post increment wrong"); // [R10]
  property p_r11_rd;
    take && c_srd |=> s_eerd_stall;
  endproperty
  a_r11_rd: assert property (p_r11_rd) else $error("read stall not four"); // [R11]
  property p_r18_gate;
    c_ctl && c_one[EC_WS] && mwe_ff == 3'h0 |=> !EE_WR;
  endproperty
  a_r18_gate: assert property (p_r18_gate) else $error("write without master enable"); // [R18]
  property p_r06_keep;
    take && c_wr && c_intl && c_ioa == IO_FLAG && !c_one[FL_WDONE] && wdone_ff |=> wdone_ff;
  endproperty
  a_r06_keep: assert property (p_r06_keep) else $error("flag cleared by zero"); // [R06]
endmodule // dsd_top

// file: test_data_space_decoder.sv
// self-checking bench for the data-space decoder
// assumes far model answers reads; eeprom write time shortened to 20 cycles
`timescale 1ns/1ps
module test_data_space_decoder;
  import dsd_pkg::*;
  typedef struct packed {
    logic [15:0] adr; dsd_tgt_s tgt; logic [7:0] dat; logic ckd; logic skp; logic cks; logic [15:0] ptr; logic ckp;
  } dsd_note_s;
  logic CORE_CLK = 1'b0, RST = 1'b1, PWR_RST = 1'b1, REQ_VALID = 1'b0;
  dsd_req_s REQ = '0;
  logic [15:0] PTR_IN = 16'h0000;
  logic READY, DONE, SKIP, PTR_WE, WR, RD, EE_WR, EE_RD, EE_BUSY, EE_READY_INT;
  logic [7:0] RDATA, WDATA, WMASK, EXT_RDATA, EE_WDATA, EE_RDATA;
  dsd_ptr_e PTR_SEL;
  logic [15:0] PTR_OUT, ADDR;
  dsd_tgt_s TGT;
  logic [8:0] EE_ADDR;
  logic [1:0] EE_MODE;
  dsd_note_s notes [$];
  dsd_note_s mon_n;
  int miscompares = 0, samples_checked = 0, cyc = 0, pwe_n = 0;
  logic [15:0] bnd [8] = '{16'h0000, 16'h001f, 16'h0020, 16'h005f, 16'h0060, 16'h00ff, 16'h0100, 16'h04ff};
  logic [5:0] gio [3] = '{IO_GPR0, IO_GPR1, IO_GPR2};
  logic [7:0] v;
  always #5 CORE_CLK = ~CORE_CLK;
  dsd_top #(.EE_WR_CYC(20)) dut (.CORE_CLK(CORE_CLK), .RST(RST), .PWR_RST(PWR_RST), .REQ_VALID(REQ_VALID),
    .REQ(REQ), .PTR_IN(PTR_IN), .READY(READY), .DONE(DONE), .SKIP(SKIP), .RDATA(RDATA), .PTR_WE(PTR_WE),
    .PTR_SEL(PTR_SEL), .PTR_OUT(PTR_OUT), .TGT(TGT), .ADDR(ADDR), .WDATA(WDATA), .WMASK(WMASK), .WR(WR),
    .RD(RD), .EXT_RDATA(EXT_RDATA), .EE_ADDR(EE_ADDR), .EE_WDATA(EE_WDATA), .EE_MODE(EE_MODE), .EE_WR(EE_WR),
    .EE_RD(EE_RD), .EE_RDATA(EE_RDATA), .EE_BUSY(EE_BUSY), .EE_READY_INT(EE_READY_INT));
  dsd_far_model far (.CORE_CLK(CORE_CLK), .ADDR(ADDR), .WDATA(WDATA), .WMASK(WMASK), .WR(WR), .RD(RD),
    .EXT_RDATA(EXT_RDATA), .EE_ADDR(EE_ADDR), .EE_WDATA(EE_WDATA), .EE_WR(EE_WR), .EE_RD(EE_RD),
    .EE_RDATA(EE_RDATA));
  task automatic results();
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp16(logic [15:0] got, logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp8(logic [7:0] got, logic [7:0] exp);
    cmp16({8'h00, got}, {8'h00, exp});
  endtask
  function automatic dsd_tgt_s tgt_of(logic [15:0] a);
    tgt_of = '{sram: a >= 16'h0100, xio: a >= 16'h0060 && a < 16'h0100, io: a >= 16'h0020 && a < 16'h0060,
      rf: a < 16'h0020};
  endfunction
  function automatic dsd_req_s mk(dsd_op_e o, dsd_am_e m, dsd_ptr_e p, logic [5:0] d, logic [15:0] a,
      logic [5:0] io, logic [2:0] b, logic [7:0] w);
    mk = '{op: o, am: m, ptr: p, disp: d, adr: a, ioa: io, bitn: b, wdat: w};
  endfunction
  function automatic dsd_note_s nt(logic [15:0] a, logic [7:0] d, logic ckd, logic skp, logic cks,
      logic [15:0] p, logic ckp);
    nt = '{adr: a, tgt: tgt_of(a), dat: d, ckd: ckd, skp: skp, cks: cks, ptr: p, ckp: ckp};
  endfunction
  // one request, held until taken; a fresh edge before each raise
  task automatic send(dsd_req_s r, logic [15:0] pin, dsd_note_s n);
    @(posedge CORE_CLK);
    REQ_VALID <= 1'b1;
    REQ <= r;
    PTR_IN <= pin;
    do @(posedge CORE_CLK); while (READY !== 1'b1);
    notes.push_back(n);
    REQ_VALID <= 1'b0;
  endtask
  task automatic st(logic [15:0] a, logic [7:0] w);
    send(mk(OP_STORE, AM_DIR, PT_X, 6'h00, a, 6'h00, 3'h0, w), 16'h0000, nt(a, 8'h00, 0, 0, 0, 16'h0000, 0));
  endtask
  task automatic ld(logic [15:0] a, logic [7:0] e, logic ck);
    send(mk(OP_LOAD, AM_DIR, PT_X, 6'h00, a, 6'h00, 3'h0, 8'h00), 16'h0000, nt(a, e, ck, 0, 0, 16'h0000, 0));
  endtask
  // port ops never reach past 0x5f, ext io only by load/store
  task automatic out(logic [5:0] io, logic [7:0] w);
    send(mk(OP_OUT, AM_DIR, PT_X, 6'h00, 16'h0000, io, 3'h0, w), 16'h0000,
      nt({10'h000, io} + 16'h0020, 8'h00, 0, 0, 0, 16'h0000, 0));
  endtask
  task automatic inp(logic [5:0] io, logic [7:0] e);
    send(mk(OP_IN, AM_DIR, PT_X, 6'h00, 16'h0000, io, 3'h0, 8'h00), 16'h0000,
      nt({10'h000, io} + 16'h0020, e, 1, 0, 0, 16'h0000, 0));
  endtask
  task automatic bop(dsd_op_e o, logic [5:0] io, logic [2:0] b, logic s, logic cks);
    send(mk(o, AM_DIR, PT_X, 6'h00, 16'h0000, io, b, 8'h00), 16'h0000,
      nt({11'h000, io[4:0]} + 16'h0020, 8'h00, 0, s, cks, 16'h0000, 0));
  endtask
  task automatic stall(int exp);
    int n;
    n = 0;
    repeat (6) begin
      @(posedge CORE_CLK);
      if (READY === 1'b0) n++;
    end
    cmp8(n[7:0], exp[7:0]);
  endtask
  task automatic wait_idle();
    for (int k = 0; k < 100 && EE_BUSY !== 1'b0; k++) @(posedge CORE_CLK);
  endtask
  always @(posedge CORE_CLK) begin
    if (DONE === 1'b1) begin
      if (notes.size() == 0) cmp8(8'h01, 8'h00);
      else begin
        mon_n = notes.pop_front();
        cmp16(ADDR, mon_n.adr);
        cmp8({4'h0, TGT}, {4'h0, mon_n.tgt});
        if (mon_n.ckd) cmp8(RDATA, mon_n.dat);
        if (mon_n.cks) cmp8({7'h00, SKIP}, {7'h00, mon_n.skp});
        if (mon_n.ckp) cmp16(PTR_OUT, mon_n.ptr);
      end
    end
  end
  always @(posedge CORE_CLK) if (PTR_WE === 1'b1) pwe_n++;
  always @(posedge CORE_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    void'($urandom(32'h6d48));
    repeat (3) @(posedge CORE_CLK);
    RST <= 1'b0;
    PWR_RST <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      st(bnd[i], v);
      if (bnd[i] >= 16'h0020) ld(bnd[i], v, 1);
    end
    ld(16'h0100, 8'h00, 0);
    stall(1);
    $display("test decode done");
    out(6'h05, 8'ha5);
    bop(OP_SBI, 6'h05, 3'h1, 0, 0);
    inp(6'h05, 8'ha7);
    bop(OP_SKBS, 6'h05, 3'h1, 1, 1);
    bop(OP_CLRB, 6'h25, 3'h0, 0, 0);
    inp(6'h05, 8'ha6);
    bop(OP_SKBC, 6'h05, 3'h0, 1, 1);
    bop(OP_SKBS, 6'h05, 3'h0, 0, 1);
    $display("test io done");
    for (int j = 0; j < 3; j++) begin
      v = $urandom;
      out(gio[j], v);
      inp(gio[j], v);
    end
    out(IO_GPR0, 8'h00);
    bop(OP_SBI, IO_GPR0, 3'h7, 0, 0);
    bop(OP_SKBS, IO_GPR0, 3'h7, 1, 1);
    inp(IO_GPR0, 8'h80);
    $display("test gpr done");
    v = $urandom;
    st(16'h023f, v);
    send(mk(OP_LOAD, AM_DISP, PT_Y, 6'h3f, 16'h0, 6'h0, 3'h0, 8'h0), 16'h0200, nt(16'h023f, v, 1, 0, 0, 16'h0, 0));
    st(16'h0150, v);
    send(mk(OP_LOAD, AM_POST, PT_X, 6'h0, 16'h0, 6'h0, 3'h0, 8'h0), 16'h0150, nt(16'h0150, v, 1, 0, 0, 16'h0151, 1));
    send(mk(OP_LOAD, AM_PRED, PT_Z, 6'h0, 16'h0, 6'h0, 3'h0, 8'h0), 16'h0151, nt(16'h0150, v, 1, 0, 0, 16'h0150, 1));
    repeat (2) @(posedge CORE_CLK);
    cmp8(pwe_n[7:0], 8'h02);
    cmp8({6'h00, PTR_SEL}, {6'h00, PT_Z});
    $display("test pointer done");
    v = $urandom;
    out(IO_EEADL, 8'h3c);
    out(IO_EEADH, 8'h01);
    out(IO_EEDAT, v);
    out(IO_EECTL, 8'h04);
    bop(OP_SBI, IO_EECTL, 3'h1, 0, 0);
    stall(2);
    cmp8({7'h00, EE_BUSY}, 8'h01);
    wait_idle();
    cmp8(far.ee[9'h13c], v);
    inp(IO_FLAG, 8'h01);
    out(IO_FLAG, 8'h00);
    inp(IO_FLAG, 8'h01);
    out(IO_FLAG, 8'h01);
    inp(IO_FLAG, 8'h00);
    bop(OP_SBI, IO_EECTL, 3'h0, 0, 0);
    stall(4);
    inp(IO_EEDAT, v);
    out(IO_EECTL, 8'h28);
    inp(IO_EECTL, 8'h28);
    cmp8({6'h00, EE_MODE}, 8'h02);
    cmp8({7'h00, EE_READY_INT}, 8'h01);
    $display("test eeprom done");
    out(IO_EECTL, 8'h04);
    repeat (8) @(posedge CORE_CLK);
    bop(OP_SBI, IO_EECTL, 3'h1, 0, 0);
    repeat (3) @(posedge CORE_CLK);
    cmp8({7'h00, EE_BUSY}, 8'h00);
    out(IO_EECTL, 8'h04);
    bop(OP_SBI, IO_EECTL, 3'h1, 0, 0);
    @(posedge CORE_CLK);
    RST <= 1'b1;
    repeat (2) @(posedge CORE_CLK);
    RST <= 1'b0;
    @(posedge CORE_CLK);
    cmp8({7'h00, EE_BUSY}, 8'h01);
    wait_idle();
    cmp8({7'h00, EE_BUSY}, 8'h00);
    $display("test strobe and reset done");
    results();
  end
endmodule // test_data_space_decoder
